// ===== logic/i2c_slave_debug.sv
// second I2C slave unit with debug address match
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_debug (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // bus lines, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // interrupts
  output logic slaveIrq,
  output logic debugIrq
);
  import i2c_slave_pkg::*;

  localparam slave_state_t RESET_STATE = '{
    state: S_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};

  slave_state_t q;
  slave_state_t d;
  logic [1:0] filtOut;
  logic sclF;
  logic sdaF;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic [4:0] holdLoad;
  logic [7:0] statusRd;
  logic [7:0] txByte;
  logic rxbSet;
  logic nackRx;

  // synchronise and filter both lines
  spike_filter u_filter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .en(q.cfg[`CFG_FILTER]),
    .din({sdaIn, sclIn}),
    .dout(filtOut)
  );

  // line events from filtered levels
  assign sclF = filtOut[0];
  assign sdaF = filtOut[1];
  assign sclRise = sclF && !q.sclPrev;
  assign sclFall = !sclF && q.sclPrev;
  assign startEv = sclF && q.sclPrev && !sdaF && q.sdaPrev;
  assign stopEv = sclF && q.sclPrev && sdaF && !q.sdaPrev;
  assign holdLoad = {1'b0, q.holdt} + `HOLD_BASE;
  assign statusRd = {q.firstB, q.addrM, q.stopF, q.rstartF,
                     q.txb, q.rxb, q.startSeen, q.nak};

  // next state: register access first, then the bus so sets win
  always_comb begin
    d = q;
    d.dbgIrq = 1'b0;
    d.rdata = 8'h00;
    d.sclPrev = sclF;
    d.sdaPrev = sdaF;
    txByte = q.again ? q.txLast : q.txData;
    rxbSet = 1'b0;
    nackRx = 1'b0;

    // register reads
    if (regRd) begin
      case (regAddr)
        `OFS_DBG_ID: d.rdata = {1'b0, q.dbgId};
        `OFS_DBG_CTRL: d.rdata = {7'h00, q.dbgEn};
        `OFS_CONFIG: d.rdata = {7'h00, q.transmit_direction_bit};
        `OFS_STATUS: d.rdata = statusRd;
        `OFS_DATA: begin
          d.rdata = q.rxData;
          d.rxb = 1'b0;
          d.firstB = 1'b0;
        end
        default: d.rdata = 8'h00;
      endcase
    end

    // register writes
    if (regWr) begin
      case (regAddr)
        `OFS_DBG_ID: d.dbgId = regWdata[6:0];
        `OFS_DBG_CTRL: d.dbgEn = regWdata[0];
        `OFS_CONFIG: d.cfg = regWdata;
        `OFS_STATUS: begin
          d.addrM = q.addrM && regWdata[`ST_ADDRM];
          d.stopF = q.stopF && regWdata[`ST_STOP];
          d.rstartF = q.rstartF && regWdata[`ST_RSTART];
          d.holdt = regWdata[3:0];
        end
        `OFS_ADDRESS: d.slaveAddr = regWdata;
        `OFS_DATA: begin
          d.txData = regWdata;
          d.txb = 1'b0;
        end
        default: d.holdt = d.holdt;
      endcase
    end

    // data output follows scl fall after the hold delay
    if (q.holdCnt != 5'h00) begin
      d.holdCnt = q.holdCnt - 5'h01;
      if (q.holdCnt == 5'h01) begin
        d.sdaOe = q.pendSda;
      end
    end

    // stretched scl is let go once data is settled
    if (q.sclOe && q.state != S_RSTR && q.state != S_TSTR
        && q.holdCnt == 5'h00) begin
      d.sclOe = 1'b0;
    end

    // bus conditions and byte engine
    if (startEv) begin
      d.rstartF = q.startSeen ? 1'b1 : d.rstartF;
      d.startSeen = 1'b1;
      d.nak = 1'b0;
      d.state = S_ADDR;
      d.bitCnt = 4'h0;
    end else if (stopEv) begin
      d.stopF = 1'b1;
      d.startSeen = 1'b0;
      d.state = S_IDLE;
    end else begin
      case (q.state)
        S_ADDR: begin
          if (sclRise) begin
            d.shift = {q.shift[6:0], sdaF};
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == 4'h8) begin
            if (q.dbgEn && q.shift[7:1] == q.dbgId) begin
              d.dbgIrq = 1'b1;
              d.dbgHit = 1'b1;
              d.pendSda = 1'b1;
              d.holdCnt = holdLoad;
              d.state = S_AACK;
            end else if (q.slaveAddr[7]
                         && q.shift[7:1] == q.slaveAddr[6:0]) begin
              d.dbgHit = 1'b0;
              d.addrM = 1'b1;
              d.transmit_direction_bit = q.shift[0];
              d.firstPend = 1'b1;
              d.pendSda = 1'b1;
              d.holdCnt = holdLoad;
              d.state = S_AACK;
            end else begin
              d.state = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (sclFall) begin
            d.bitCnt = 4'h0;
            d.holdCnt = holdLoad;
            if (q.dbgHit) begin
              d.pendSda = 1'b0;
              d.state = S_IDLE;
            end else if (q.transmit_direction_bit) begin
              d.shift = txByte;
              d.txLast = txByte;
              d.txb = 1'b1;
              d.pendSda = !txByte[7];
              d.state = S_TX;
            end else begin
              d.pendSda = 1'b0;
              d.state = S_RX;
            end
          end
        end
        S_RX: begin
          if (sclRise) begin
            d.shift = {q.shift[6:0], sdaF};
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == 4'h8) begin
            if (!q.rxb) begin
              rxbSet = 1'b1;
              d.state = S_RACK;
            end else if (q.cfg[`CFG_STRETCH]) begin
              d.sclOe = 1'b1;
              d.state = S_RSTR;
            end else begin
              nackRx = 1'b1;
              d.pendSda = 1'b0;
              d.holdCnt = holdLoad;
              d.state = S_RACK;
            end
          end
        end
        S_RSTR: begin
          if (!q.rxb) begin
            rxbSet = 1'b1;
            d.state = S_RACK;
          end
        end
        S_RACK: begin
          if (sclFall) begin
            d.pendSda = 1'b0;
            d.holdCnt = holdLoad;
            d.bitCnt = 4'h0;
            d.state = S_RX;
          end
        end
        S_TX: begin
          if (sclRise) begin
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == 4'h8) begin
            d.pendSda = 1'b0;
            d.holdCnt = holdLoad;
            d.state = S_TACK;
          end else if (sclFall && q.bitCnt != 4'h0) begin
            d.pendSda = !q.shift[3'(4'h7 - q.bitCnt)];
            d.holdCnt = holdLoad;
          end
        end
        S_TACK: begin
          if (sclRise) begin
            if (sdaF) begin
              d.nak = 1'b1;
              d.again = 1'b1;
              d.state = S_IDLE;
            end else begin
              d.nak = 1'b0;
              d.again = 1'b0;
            end
          end else if (sclFall) begin
            d.bitCnt = 4'h0;
            d.holdCnt = holdLoad;
            d.state = S_TX;
            if (!q.txb) begin
              d.shift = q.txData;
              d.txLast = q.txData;
              d.txb = 1'b1;
              d.pendSda = !q.txData[7];
            end else if (q.cfg[`CFG_STRETCH]) begin
              d.sclOe = 1'b1;
              d.holdCnt = 5'h00;
              d.state = S_TSTR;
            end else begin
              d.shift = q.txLast;
              d.nak = 1'b1;
              d.pendSda = !q.txLast[7];
            end
          end
        end
        S_TSTR: begin
          if (!q.txb) begin
            d.shift = q.txData;
            d.txLast = q.txData;
            d.txb = 1'b1;
            d.pendSda = !q.txData[7];
            d.holdCnt = holdLoad;
            d.bitCnt = 4'h0;
            d.state = S_TX;
          end
        end
        default: d.state = S_IDLE;
      endcase
    end

    // move a received byte to software and acknowledge it
    if (rxbSet) begin
      d.rxData = q.shift;
      d.rxb = 1'b1;
      d.firstB = q.firstPend;
      d.firstPend = 1'b0;
      d.pendSda = 1'b1;
      d.holdCnt = holdLoad;
    end

    // soft reset holds every engine idle and clears the address
    if (q.cfg[`CFG_SRST]) begin
      d.state = S_IDLE;
      d.slaveAddr = `REG_RESET;
      d.bitCnt = 4'h0;
      d.startSeen = 1'b0;
      d.pendSda = 1'b0;
      d.holdCnt = 5'h00;
      d.sdaOe = 1'b0;
      d.sclOe = 1'b0;
      d.again = 1'b0;
    end

    // gated interrupt request
    d.irq = |({q.addrM, q.stopF, q.rstartF, q.txb, q.rxb} & q.cfg[6:2]);
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign regRdata = q.rdata;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = q.sclOe;
  assign sdaOe = q.sdaOe;
  assign slaveIrq = q.irq;
  assign debugIrq = q.dbgIrq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_debug_hit;
    (q.state == S_ADDR && sclFall && q.bitCnt == 4'h8 && q.dbgEn
     && q.shift[7:1] == q.dbgId && !startEv && !stopEv) |=> debugIrq;
  endproperty
  a_debug_hit: assert property (p_debug_hit)
    else $error("debug address matched without debug interrupt");

  property p_direction;
    (q.state == S_ADDR && sclFall && q.bitCnt == 4'h8 && !q.dbgEn
     && q.slaveAddr[7] && q.shift[7:1] == q.slaveAddr[6:0]
     && !startEv && !stopEv && !q.cfg[7])
      |=> q.transmit_direction_bit == $past(q.shift[0]) && q.addrM;
  endproperty
  a_direction: assert property (p_direction)
    else $error("direction bit or match flag wrong after address");

  property p_rx_flag;
    rxbSet && !q.cfg[7] |=> q.rxb && q.rxData == $past(q.shift);
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("received byte not posted");

  property p_rx_master_nak_flag;
    nackRx && !q.cfg[7] |=> !q.pendSda && q.rxData == $past(q.rxData);
  endproperty
  a_rx_master_nak_flag: assert property (p_rx_master_nak_flag)
    else $error("full receive buffer was acknowledged");

  property p_tx_clear;
    (regWr && regAddr == `OFS_DATA && q.state != S_AACK
     && q.state != S_TACK && q.state != S_TSTR) |=> !q.txb;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("data write did not clear transmit flag");

  property p_stop;
    stopEv && !startEv |=> q.stopF && !q.startSeen;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop not recorded");

  property p_soft_reset;
    q.cfg[7] |=> q.state == S_IDLE && q.slaveAddr == 8'h00 && !q.sclOe;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset left state active");

  property p_irq_gate;
    ##1 slaveIrq == $past(|({q.addrM, q.stopF, q.rstartF, q.txb, q.rxb}
                            & q.cfg[6:2]));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("slave interrupt not gated by enables");

  property p_hold_time;
    ($changed(sdaOe) && !$past(q.cfg[7])) |-> $past(q.holdCnt) == 5'h01;
  endproperty
  a_hold_time: assert property (p_hold_time)
    else $error("SDA changed outside the hold delay");
endmodule : i2c_slave_debug
`default_nettype wire

// ===== logic/i2c_slave_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

`define OFS_DBG_ID 8'hd9
`define OFS_DBG_CTRL 8'hda
`define OFS_CONFIG 8'hdb
`define OFS_STATUS 8'hdc
`define OFS_ADDRESS 8'hdd
`define OFS_DATA 8'hde

`define CFG_SRST 7
`define CFG_STRETCH 1
`define CFG_FILTER 0
`define ST_ADDRM 6
`define ST_STOP 5
`define ST_RSTART 4

`define REG_RESET 8'h00
`define HOLD_BASE 5'h03
`define CLK_PERIOD_NS 4
`define SPIKE_NS 50
`define SPIKE_CYC ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== logic/i2c_slave_pkg.sv
// types shared by the second slave unit and its input filter
`include "i2c_slave_params.svh"
package i2c_slave_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_RSTR, S_TX, S_TACK, S_TSTR
  } bus_state_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] out;
    logic [1:0][3:0] cnt;
  } filt_state_t;

  typedef struct packed {
    bus_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] rxData;
    logic [7:0] txData;
    logic [7:0] txLast;
    logic [7:0] cfg;
    logic [7:0] slaveAddr;
    logic [6:0] dbgId;
    logic dbgEn;
    logic dbgHit;
    logic dbgIrq;
    logic transmit_direction_bit;
    logic startSeen;
    logic firstPend;
    logic firstB;
    logic addrM;
    logic stopF;
    logic rstartF;
    logic txb;
    logic rxb;
    logic nak;
    logic again;
    logic [3:0] holdt;
    logic sclPrev;
    logic sdaPrev;
    logic pendSda;
    logic [4:0] holdCnt;
    logic sdaOe;
    logic sclOe;
    logic irq;
    logic [7:0] rdata;
  } slave_state_t;
endpackage : i2c_slave_pkg

// ===== logic/spike_filter.sv
// two-flop synchroniser and spike filter for the SCL and SDA inputs
`timescale 1ns/100ps
`default_nettype none
module spike_filter
  import i2c_slave_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic en,
  // lines
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  import i2c_slave_pkg::*;

  localparam logic [3:0] LAST = 4'(`SPIKE_CYC - 1);
  filt_state_t q;
  filt_state_t d;

  // a level must stay stable for the whole window before it passes
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    for (int i = 0; i < 2; i++) begin
      if (!en) begin
        d.out[i] = q.s2[i];
        d.cnt[i] = 4'h0;
      end else if (q.s2[i] == q.out[i]) begin
        d.cnt[i] = 4'h0;
      end else if (q.cnt[i] == LAST) begin
        d.out[i] = q.s2[i];
        d.cnt[i] = 4'h0;
      end else begin
        d.cnt[i] = q.cnt[i] + 4'h1;
      end
    end
  end

  // state register, lines idle high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{s1: 2'h3, s2: 2'h3, out: 2'h3, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign dout = q.out;

  property p_filter_window;
    @(posedge clk_sys) disable iff (sys_rst)
      ($past(en) && $changed(q.out[0])) |-> $past(q.cnt[0]) == LAST;
  endproperty
  a_filter_window: assert property (p_filter_window)
    else $error("filtered SCL changed before the spike window ended");
endmodule : spike_filter
`default_nettype wire

// ===== verif/i2c_master_model.sv
// behavioural bus master that drives the open-drain lines of the slave unit
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  // clock
  input wire logic clk_sys,
  // slave pull-down enables
  input wire logic sclOe,
  input wire logic sdaOe,
  // resolved lines
  output wire sclLine,
  output wire sdaLine
);
  logic sclM = 1'b1;
  logic sdaM = 1'b1;

  // pull-up lines: a released line reads high, any puller wins
  assign sclLine = sclM & ~sclOe;
  assign sdaLine = sdaM & ~sdaOe;

  // one link tick is 8 system cycles, 32 ns
  task automatic tick(input int n);
    repeat (n * 8) @(posedge clk_sys);
  endtask : tick

  // start or repeated start, scl left low
  task automatic start();
    sdaM <= 1'b1;
    tick(1);
    sclM <= 1'b1;
    tick(2);
    sdaM <= 1'b0;
    tick(2);
    sclM <= 1'b0;
    tick(1);
  endtask : start

  // stop from scl low
  task automatic stop();
    sdaM <= 1'b0;
    tick(1);
    sclM <= 1'b1;
    tick(2);
    sdaM <= 1'b1;
    tick(2);
  endtask : stop

  // short low pulse on sda while scl is high
  task automatic glitch(input int n);
    sdaM <= 1'b0;
    repeat (n) @(posedge clk_sys);
    sdaM <= 1'b1;
    tick(2);
  endtask : glitch

  // one bit: low phase long enough for the slave hold count, then high
  task automatic bitx(input logic b, output logic r);
    int k;
    sdaM <= b;
    tick(3);
    sclM <= 1'b1;
    // a stretching slave keeps scl low; wait for it, bounded
    for (k = 0; k < 4000 && sclLine !== 1'b1; k++) begin
      @(posedge clk_sys);
    end
    tick(1);
    r = sdaLine;
    tick(1);
    sclM <= 1'b0;
    tick(1);
  endtask : bitx

  // write one byte msb first, report the slave acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = (r === 1'b0);
  endtask : wbyte

  // read one byte, then answer with ack or master_nak_flag
  task automatic rbyte(input logic ackM, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~ackM, r);
  endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

// ===== verif/test_i2c_slave_debug.sv
// self-checking bench for the second slave unit with debug address
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_params.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_fail++; $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end end
module test_i2c_slave_debug;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic sclOe, sdaOe, slaveIrq, debugIrq;
  wire sclLine, sdaLine;
  int n_fail = 0;
  int n_compared = 0;
  int dbgCnt = 0;
  logic ack;
  logic [7:0] d;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  // count debug pulses
  always @(negedge clk_sys) if (debugIrq === 1'b1) dbgCnt <= dbgCnt + 1;

  i2c_slave_debug i_i2c_slave_debug (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sclIn(sclLine), .sclOut(), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .slaveIrq(slaveIrq),
    .debugIrq(debugIrq)
  );

  i2c_master_model i_i2c_master_model (
    .clk_sys(clk_sys), .sclOe(sclOe), .sdaOe(sdaOe),
    .sclLine(sclLine), .sdaLine(sdaLine)
  );

  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  // register read, data taken in the cycle after the strobe
  task automatic expReg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask : expReg

  // reset values and unmapped place
  task automatic t_reset();
    `CHK({sclOe, sdaOe, slaveIrq, debugIrq}, 4'h0)
    expReg(`OFS_CONFIG, 8'h00);
    expReg(`OFS_STATUS, 8'h00);
    expReg(`OFS_ADDRESS, 8'h00);
    expReg(`OFS_DATA, 8'h00);
    expReg(8'h00, 8'h00);
  endtask : t_reset

  // receive one byte with match interrupt enabled
  task automatic t_rx();
    wr(`OFS_ADDRESS, 8'haa);
    wr(`OFS_CONFIG, 8'h40);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b0}, ack);
    `CHK(ack, 1'b1)
    expReg(`OFS_STATUS, 8'h42);
    `CHK(slaveIrq, 1'b1)
    i_i2c_master_model.wbyte(8'h5c, ack);
    `CHK(ack, 1'b1)
    expReg(`OFS_STATUS, 8'hc6);
    expReg(`OFS_CONFIG, 8'h00);
    expReg(`OFS_DATA, 8'h5c);
    expReg(`OFS_STATUS, 8'h42);
    wr(`OFS_STATUS, 8'h00);
    repeat (4) @(posedge clk_sys);
    `CHK(slaveIrq, 1'b0)
    i_i2c_master_model.stop();
    expReg(`OFS_STATUS, 8'h20);
    wr(`OFS_STATUS, 8'h00);
  endtask : t_rx

  // unread byte with stretching off answered with master_nak_flag
  task automatic t_overrun();
    wr(`OFS_CONFIG, 8'h00);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b0}, ack);
    i_i2c_master_model.wbyte(8'h11, ack);
    i_i2c_master_model.wbyte(8'h22, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
    expReg(`OFS_DATA, 8'h11);
    wr(`OFS_STATUS, 8'h00);
  endtask : t_overrun

  // unread byte with stretching on holds scl until read
  task automatic t_stretch();
    wr(`OFS_CONFIG, 8'h02);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b0}, ack);
    i_i2c_master_model.wbyte(8'h33, ack);
    fork
      i_i2c_master_model.wbyte(8'h44, ack);
      begin
        repeat (1000) @(posedge clk_sys);
        `CHK(sclOe, 1'b1)
        expReg(`OFS_DATA, 8'h33);
      end
    join
    `CHK(ack, 1'b1)
    expReg(`OFS_DATA, 8'h44);
    i_i2c_master_model.stop();
    wr(`OFS_STATUS, 8'h00);
  endtask : t_stretch

  // transmit, reload without new data, master master_nak_flag and resend
  task automatic t_tx();
    wr(`OFS_CONFIG, 8'h00);
    wr(`OFS_DATA, 8'ha5);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b1}, ack);
    `CHK(ack, 1'b1)
    expReg(`OFS_CONFIG, 8'h01);
    i_i2c_master_model.rbyte(1'b1, d);
    `CHK(d, 8'ha5)
    expReg(`OFS_STATUS, 8'h4b);
    i_i2c_master_model.rbyte(1'b0, d);
    `CHK(d, 8'ha5)
    `CHK(sdaOe, 1'b0)
    wr(`OFS_STATUS, 8'h00);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b1}, ack);
    expReg(`OFS_STATUS, 8'h5a);
    i_i2c_master_model.rbyte(1'b0, d);
    `CHK(d, 8'ha5)
    i_i2c_master_model.stop();
    wr(`OFS_DATA, 8'h00);
    wr(`OFS_STATUS, 8'h00);
  endtask : t_tx

  // transmit with stretching on: resend after master_nak_flag, then hold scl for data
  task automatic t_txstretch();
    wr(`OFS_CONFIG, 8'h02);
    wr(`OFS_DATA, 8'h96);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b1}, ack);
    `CHK(ack, 1'b1)
    i_i2c_master_model.rbyte(1'b1, d);
    `CHK(d, 8'ha5)
    fork
      i_i2c_master_model.rbyte(1'b0, d);
      begin
        repeat (200) @(posedge clk_sys);
        `CHK(sclOe, 1'b1)
        wr(`OFS_DATA, 8'h3c);
      end
    join
    `CHK(d, 8'h3c)
    i_i2c_master_model.stop();
    wr(`OFS_DATA, 8'h00);
    wr(`OFS_STATUS, 8'h00);
  endtask : t_txstretch

  // debug address with enable on and off
  task automatic t_debug();
    int c0;
    wr(`OFS_DBG_ID, 8'h3c);
    wr(`OFS_DBG_CTRL, 8'h01);
    c0 = dbgCnt;
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h3c, 1'b0}, ack);
    `CHK(ack, 1'b1)
    `CHK(dbgCnt - c0, 1)
    i_i2c_master_model.stop();
    expReg(`OFS_STATUS, 8'h20);
    wr(`OFS_DBG_CTRL, 8'h00);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h3c, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
    `CHK(dbgCnt - c0, 1)
    wr(`OFS_STATUS, 8'h00);
  endtask : t_debug

  // spike on sda with filter on and off
  task automatic t_filter();
    wr(`OFS_CONFIG, 8'h01);
    i_i2c_master_model.glitch(5);
    expReg(`OFS_STATUS, 8'h00);
    wr(`OFS_CONFIG, 8'h00);
    i_i2c_master_model.glitch(5);
    expReg(`OFS_STATUS, 8'h20);
    wr(`OFS_STATUS, 8'h00);
  endtask : t_filter

  // soft reset clears the address register
  task automatic t_softreset();
    wr(`OFS_CONFIG, 8'h80);
    wr(`OFS_CONFIG, 8'h00);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({7'h2a, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
    expReg(`OFS_STATUS, 8'h20);
  endtask : t_softreset

  // counts and verdict
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_rx();
    t_overrun();
    t_stretch();
    t_tx();
    t_txstretch();
    t_debug();
    t_filter();
    t_softreset();
    end_of_test();
  end

  // watchdog against a hung bus
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end
endmodule : test_i2c_slave_debug
`default_nettype wire
